// [ppb_bus_if.sv]
// interface carrying the primary bus between the device end and the host end
`default_nettype none
interface ppb_bus_if;
  logic [31:0] ad_dev_o, ad_host_o;
  logic ad_dev_oe, ad_host_oe;
  logic [3:0] cbe_dev_o, cbe_host_o;
  logic cbe_dev_oe, cbe_host_oe;
  logic par_dev_o, par_host_o, par_dev_oe, par_host_oe;
  logic frame_n_dev_o, frame_n_host_o, frame_n_dev_oe, frame_n_host_oe;
  logic irdy_n_dev_o, irdy_n_host_o, irdy_n_dev_oe, irdy_n_host_oe;
  logic trdy_n_dev_o, trdy_n_host_o, trdy_n_dev_oe, trdy_n_host_oe;
  logic devsel_n_dev_o, devsel_n_host_o, devsel_n_dev_oe, devsel_n_host_oe;
  logic stop_n_dev_o, stop_n_host_o, stop_n_dev_oe, stop_n_host_oe;
  logic perr_n_dev_o, perr_n_dev_oe;
  logic serr_n_dev_o;
  logic req_n, gnt_n, idsel;
  // resolved wire levels; undriven strobes and cbe float high, undriven ad and par resolve low
  wire [31:0] ad = ad_dev_oe ? ad_dev_o : (ad_host_oe ? ad_host_o : 32'h0000_0000);
  wire [3:0] cbe = cbe_dev_oe ? cbe_dev_o : (cbe_host_oe ? cbe_host_o : 4'hf);
  wire par = par_dev_oe ? par_dev_o : (par_host_oe ? par_host_o : 1'b0);
  wire frame_n = frame_n_dev_oe ? frame_n_dev_o : (frame_n_host_oe ? frame_n_host_o : 1'b1);
  wire irdy_n = irdy_n_dev_oe ? irdy_n_dev_o : (irdy_n_host_oe ? irdy_n_host_o : 1'b1);
  wire trdy_n = trdy_n_dev_oe ? trdy_n_dev_o : (trdy_n_host_oe ? trdy_n_host_o : 1'b1);
  wire devsel_n = devsel_n_dev_oe ? devsel_n_dev_o :
    (devsel_n_host_oe ? devsel_n_host_o : 1'b1);
  wire stop_n = stop_n_dev_oe ? stop_n_dev_o : (stop_n_host_oe ? stop_n_host_o : 1'b1);
  wire perr_n = perr_n_dev_oe ? perr_n_dev_o : 1'b1;
  modport dev (
    input ad, cbe, par, frame_n, irdy_n, trdy_n, devsel_n, stop_n, gnt_n, idsel,
    output ad_dev_o, ad_dev_oe, cbe_dev_o, cbe_dev_oe, par_dev_o, par_dev_oe,
    output frame_n_dev_o, frame_n_dev_oe, irdy_n_dev_o, irdy_n_dev_oe,
    output trdy_n_dev_o, trdy_n_dev_oe, devsel_n_dev_o, devsel_n_dev_oe,
    output stop_n_dev_o, stop_n_dev_oe, perr_n_dev_o, perr_n_dev_oe, serr_n_dev_o, req_n
  );
  modport host (
    input ad, cbe, par, frame_n, irdy_n, trdy_n, devsel_n, stop_n, perr_n, serr_n_dev_o,
    input req_n,
    output ad_host_o, ad_host_oe, cbe_host_o, cbe_host_oe, par_host_o, par_host_oe,
    output frame_n_host_o, frame_n_host_oe, irdy_n_host_o, irdy_n_host_oe,
    output trdy_n_host_o, trdy_n_host_oe, devsel_n_host_o, devsel_n_host_oe,
    output stop_n_host_o, stop_n_host_oe, gnt_n, idsel
  );
endinterface : ppb_bus_if
`default_nettype wire

// [ppb_chk.sv]
// assertions watching the primary bus between the two ends
`default_nettype none
module ppb_chk #(
  parameter int ABORT_LIMIT = 5
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] cbe,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic devsel_n,
  input wire logic idsel,
  input wire logic gnt_n,
  input wire logic serr_n_dev_o,
  input wire logic [31:0] ad_dev_o,
  input wire logic ad_dev_oe,
  input wire logic [3:0] cbe_dev_o,
  input wire logic cbe_dev_oe,
  input wire logic par_dev_o,
  input wire logic par_dev_oe,
  input wire logic frame_n_dev_o,
  input wire logic frame_n_dev_oe,
  input wire logic irdy_n_dev_o,
  input wire logic irdy_n_dev_oe,
  input wire logic trdy_n_dev_o,
  input wire logic trdy_n_dev_oe,
  input wire logic devsel_n_dev_o,
  input wire logic devsel_n_dev_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // unclaimed wait counter: clocks of device ready with no claim
  logic [7:0] wait_cnt_ff;
  wire dev_irdy = irdy_n_dev_oe && !irdy_n_dev_o;
  wire [7:0] nxt_wait_cnt = (dev_irdy && devsel_n) ? wait_cnt_ff + 8'h01 : 8'h00;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt_ff <= 8'h00;
    end else begin
      wait_cnt_ff <= nxt_wait_cnt;
    end
  end
  // ==========================================================
  // properties, all in the bus clock domain
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // config address phase from the host; idsel path only, strap-low mode unseen here
  sequence s_cfg_addr;
    $fell(frame_n) && idsel && (cbe[3:1] == 3'h5) && !frame_n_dev_oe;
  endsequence
  sequence s_dev_addr;
    frame_n_dev_oe && !frame_n_dev_o;
  endsequence
  a_par_follows: assert property ((ad_dev_oe && cbe_dev_oe) |=>
    par_dev_oe && (par_dev_o == ^{$past(ad_dev_o), $past(cbe_dev_o)}))
    else $error("parity not driven one clock after address or data");
  a_claim_cfg: assert property (s_cfg_addr |=>
    devsel_n_dev_oe && !devsel_n_dev_o && !trdy_n_dev_o)
    else $error("config cycle not claimed");
  a_ignore_other: assert property (($fell(frame_n) && !frame_n_dev_oe &&
    (cbe[3:1] != 3'h5)) |=> (!(devsel_n_dev_oe && !devsel_n_dev_o))[*3])
    else $error("non-config cycle claimed");
  a_single_data: assert property ((trdy_n_dev_oe && !trdy_n_dev_o && !irdy_n)
    |=> trdy_n) else $error("target ready held past completed phase");
  a_frame_last: assert property (s_dev_addr |=>
    frame_n && irdy_n_dev_oe && !irdy_n_dev_o)
    else $error("frame not released on final data phase");
  a_grant_first: assert property (s_dev_addr |-> $past(!gnt_n))
    else $error("frame driven without grant");
  a_abort_bound: assert property (wait_cnt_ff <= 8'(ABORT_LIMIT + 1))
    else $error("unclaimed cycle not aborted in time");
  a_serr_pulse: assert property (!serr_n_dev_o |=> serr_n_dev_o)
    else $error("system error not a single pulse");
endmodule // ppb_chk
`default_nettype wire

// [ppb_device.sv]
// device end of the primary bus: config target plus single-word initiator
`default_nettype none
module ppb_device
  import ppb_pkg::*;
#(
  parameter int ABORT_LIMIT = ABORT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  ppb_bus_if.dev bus,
  input wire logic latch_strap,
  input wire logic sys_err,
  input wire logic card_addr_perr,
  input wire logic mst_start,
  input wire logic mst_write,
  input wire logic [3:0] mst_cmd,
  input wire logic [31:0] mst_addr,
  input wire logic [31:0] mst_wdata,
  input wire logic [3:0] mst_be,
  output logic mst_done_ff,
  output logic mst_abort_ff,
  output logic [31:0] mst_rdata_ff,
  output logic lock_sel_ff,
  output logic [31:0] cmd_reg_ff
);
  initial begin
    if (ABORT_LIMIT < 1 || ABORT_LIMIT > 255) $error("ABORT_LIMIT out of range");
  end
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_REQ = 3'b001, ST_ADDR = 3'b010, ST_DATA = 3'b011,
    ST_TGT = 3'b100, ST_TURN = 3'b101
  } ppb_st_e;
  ppb_st_e st_ff, nxt_st;
  // ==========================================================
  // pin synchronisers (strap only; bus runs on this clock)
  logic strap_s1_ff, strap_s2_ff, strap_low_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_ff <= 1'b1;
      strap_s2_ff <= 1'b1;
    end else begin
      strap_s1_ff <= latch_strap;
      strap_s2_ff <= strap_s1_ff;
    end
  end
  // ==========================================================
  // registers and latched phase state
  logic [31:0] brc_ff, mfr_ff, ad_o_ff, tgt_addr_ff;
  logic [3:0] cbe_o_ff;
  logic [7:0] cnt_ff;
  logic ad_oe_ff, cbe_oe_ff, par_ff, par_oe_ff, frame_ff, irdy_ff, trdy_ff, devsel_ff;
  logic stop_ff, perr_ff, perr_oe_ff, serr_ff, req_ff, tgt_wr_ff, chk_ff, calc_par_ff;
  logic [1:0] strap_age_ff; // strap must settle through both flops before capture
  // ==========================================================
  // decode
  wire frame_a = !bus.frame_n;
  wire xfer = !bus.irdy_n && !bus.trdy_n;
  wire cfg_sel = strap_low_ff ? bus.ad[ADDR_IDSEL_ALT] : bus.idsel;
  wire is_cfg = bus.cbe[3:1] == CMD_CFG_READ[3:1];
  wire claim = (st_ff == ST_IDLE) && frame_a && cfg_sel && is_cfg;
  wire calc_par = ^{bus.ad, bus.cbe};
  wire my_par = ^{ad_o_ff, bus.cbe}; // lanes as seen on the wire
  wire par_err = chk_ff && (calc_par_ff != bus.par); // parity lags its phase
  // read offset straight off the bus in the claim cycle, so data meets trdy
  wire [7:0] rd_ofs = claim ? bus.ad[7:0] : tgt_addr_ff[7:0];
  wire [31:0] rd_word = rd_ofs == OFS_COMMAND ? cmd_reg_ff :
    rd_ofs == OFS_BRIDGE_CTRL ? brc_ff :
    rd_ofs == OFS_MF_ROUTING ? mfr_ff : 32'h0000_0000;
  // byte-lane merge for config writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be_n);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (!be_n[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction
  wire wr_hit = st_ff == ST_TGT && tgt_wr_ff && xfer;
  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE: begin
        if (claim) nxt_st = ST_TGT;
        else if (mst_start || req_ff) nxt_st = ST_REQ;
      end
      ST_REQ: if (!bus.gnt_n && !frame_a && bus.irdy_n) nxt_st = ST_ADDR;
      ST_ADDR: nxt_st = ST_DATA;
      ST_DATA: begin
        if (xfer || !bus.stop_n || cnt_ff == 8'(ABORT_LIMIT)) nxt_st = ST_TURN;
      end
      ST_TGT: if (xfer || bus.frame_n && bus.irdy_n) nxt_st = ST_TURN;
      ST_TURN: nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end
  // ==========================================================
  // state, counters, strap capture on the third clock after release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      strap_low_ff <= 1'b0;
      strap_age_ff <= 2'h0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= (st_ff == ST_DATA && bus.devsel_n) ? cnt_ff + 8'h01 : 8'h00;
      if (strap_age_ff != 2'h3) strap_age_ff <= strap_age_ff + 2'h1;
      if (strap_age_ff == 2'h2) strap_low_ff <= !strap_s2_ff;
    end
  end
  // ==========================================================
  // configuration registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg_ff <= RST_COMMAND;
      brc_ff <= RST_BRIDGE_CTRL;
      mfr_ff <= RST_MF_ROUTING;
      lock_sel_ff <= 1'b0;
    end else begin
      if (wr_hit && tgt_addr_ff[7:0] == OFS_COMMAND)
        cmd_reg_ff <= be_merge(cmd_reg_ff, bus.ad, bus.cbe);
      if (wr_hit && tgt_addr_ff[7:0] == OFS_BRIDGE_CTRL)
        brc_ff <= be_merge(brc_ff, bus.ad, bus.cbe);
      if (wr_hit && tgt_addr_ff[7:0] == OFS_MF_ROUTING)
        mfr_ff <= be_merge(mfr_ff, bus.ad, bus.cbe);
      lock_sel_ff <= mfr_ff[MF7_LSB +: 4] == MF7_SEL_LOCK && strap_low_ff;
    end
  end
  // ==========================================================
  // target side: claim, ready, stop, parity checking, perr and serr
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_addr_ff <= 32'h0000_0000;
      tgt_wr_ff <= 1'b0;
      devsel_ff <= 1'b0;
      trdy_ff <= 1'b0;
      stop_ff <= 1'b0;
      chk_ff <= 1'b0;
      calc_par_ff <= 1'b0;
      perr_ff <= 1'b0;
      perr_oe_ff <= 1'b0;
      serr_ff <= 1'b0;
    end else begin
      if (claim) begin
        tgt_addr_ff <= bus.ad;
        tgt_wr_ff <= bus.cbe[0];
      end
      devsel_ff <= claim || (st_ff == ST_TGT && !xfer && !(bus.frame_n && bus.irdy_n));
      trdy_ff <= devsel_ff ? (st_ff == ST_TGT && !xfer) : claim;
      stop_ff <= st_ff == ST_TGT && !xfer && !bus.frame_n; // single word: disconnect
      chk_ff <= claim || wr_hit; // check address phase and written data
      calc_par_ff <= calc_par;
      perr_ff <= par_err && cmd_reg_ff[CMD_PERR_EN_BIT];
      perr_oe_ff <= perr_ff || (par_err && cmd_reg_ff[CMD_PERR_EN_BIT]);
      serr_ff <= cmd_reg_ff[CMD_SERR_EN_BIT] &&
        (sys_err || (card_addr_perr && brc_ff[BRC_CB_SERR_BIT]));
    end
  end
  // ==========================================================
  // initiator side and shared address/data drive
  wire mst_drv_ad = nxt_st == ST_ADDR || (nxt_st == ST_DATA && mst_write);
  wire tgt_drv_ad = (claim && !bus.cbe[0]) || (st_ff == ST_TGT && !tgt_wr_ff);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ff <= 1'b0;
      frame_ff <= 1'b0;
      irdy_ff <= 1'b0;
      ad_o_ff <= 32'h0000_0000;
      ad_oe_ff <= 1'b0;
      cbe_o_ff <= 4'hf;
      cbe_oe_ff <= 1'b0;
      par_ff <= 1'b0;
      par_oe_ff <= 1'b0;
      mst_done_ff <= 1'b0;
      mst_abort_ff <= 1'b0;
      mst_rdata_ff <= 32'h0000_0000;
    end else begin
      if (mst_start) req_ff <= 1'b1;
      else if (nxt_st == ST_ADDR) req_ff <= 1'b0;
      frame_ff <= nxt_st == ST_ADDR; // one data phase: frame drops with irdy up
      irdy_ff <= nxt_st == ST_DATA && !(st_ff == ST_DATA);
      if (st_ff == ST_DATA && !xfer && bus.stop_n && cnt_ff != 8'(ABORT_LIMIT)) irdy_ff <= 1'b1;
      if (nxt_st == ST_ADDR) begin
        ad_o_ff <= mst_addr;
        cbe_o_ff <= mst_cmd;
      end else if (nxt_st == ST_DATA && st_ff == ST_ADDR) begin
        ad_o_ff <= mst_wdata;
        cbe_o_ff <= mst_be;
      end else if (tgt_drv_ad) begin
        ad_o_ff <= rd_word;
      end
      ad_oe_ff <= mst_drv_ad || tgt_drv_ad;
      cbe_oe_ff <= nxt_st == ST_ADDR || nxt_st == ST_DATA;
      par_ff <= my_par;
      par_oe_ff <= ad_oe_ff;
      mst_done_ff <= st_ff == ST_DATA && nxt_st == ST_TURN;
      mst_abort_ff <= st_ff == ST_DATA && cnt_ff == 8'(ABORT_LIMIT) && !xfer;
      if (st_ff == ST_DATA && xfer && !mst_write) mst_rdata_ff <= bus.ad;
    end
  end
  // ==========================================================
  // pin drive; strobes are active low
  assign bus.ad_dev_o = ad_o_ff;
  assign bus.ad_dev_oe = ad_oe_ff;
  assign bus.cbe_dev_o = cbe_o_ff;
  assign bus.cbe_dev_oe = cbe_oe_ff;
  assign bus.par_dev_o = par_ff;
  assign bus.par_dev_oe = par_oe_ff;
  assign bus.frame_n_dev_o = !frame_ff;
  assign bus.frame_n_dev_oe = frame_ff || irdy_ff;
  assign bus.irdy_n_dev_o = !irdy_ff;
  assign bus.irdy_n_dev_oe = irdy_ff || frame_ff;
  assign bus.trdy_n_dev_o = !trdy_ff;
  assign bus.trdy_n_dev_oe = devsel_ff;
  assign bus.devsel_n_dev_o = !devsel_ff;
  assign bus.devsel_n_dev_oe = devsel_ff;
  assign bus.stop_n_dev_o = !stop_ff;
  assign bus.stop_n_dev_oe = devsel_ff;
  assign bus.perr_n_dev_o = !perr_ff;
  assign bus.perr_n_dev_oe = perr_oe_ff;
  assign bus.serr_n_dev_o = !serr_ff;
  assign bus.req_n = !req_ff;
endmodule // ppb_device
`default_nettype wire

// [ppb_host.sv]
// host end: arbiter, single-word initiator and simple memory target
`default_nettype none
module ppb_host
  import ppb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  ppb_bus_if.host bus,
  input wire logic park,
  input wire logic cfg_sel_in,
  input wire logic hst_start,
  input wire logic [3:0] hst_cmd,
  input wire logic [31:0] hst_addr,
  input wire logic [31:0] hst_wdata,
  input wire logic [3:0] hst_be,
  output logic hst_done_ff,
  output logic [31:0] hst_rdata_ff,
  output logic serr_seen_ff
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_ADDR = 2'b01, HS_DATA = 2'b10, HS_TURN = 2'b11
  } ppb_hs_e;
  ppb_hs_e st_ff;
  logic gnt_ff, frame_ff, irdy_ff, oe_ff, wr_ff, trdy_ff, devsel_ff, idsel_ff, pend_ff;
  logic [31:0] ad_ff, mem_ff; // mem_ff: the one word this end serves as target
  logic [2:0] hto_ff;
  logic twr_ff;
  logic [3:0] cbe_ff;
  logic par_ff, par_oe_ff;
  // ==========================================================
  // decode
  wire xfer = !bus.irdy_n && !bus.trdy_n;
  wire dev_busy = !bus.req_n;
  wire mem_claim = st_ff == HS_IDLE && !bus.frame_n && gnt_ff && !devsel_ff &&
    bus.cbe[3:1] == CMD_MEM_READ[3:1]; // memory commands only
  wire go = st_ff == HS_IDLE && pend_ff && !dev_busy && bus.frame_n && bus.irdy_n;
  // ==========================================================
  // arbiter: grant on request or when parked on the device
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) gnt_ff <= 1'b0;
    else gnt_ff <= (dev_busy || park) && st_ff == HS_IDLE && !pend_ff;
  end
  // ==========================================================
  // initiator sequence
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= HS_IDLE;
      pend_ff <= 1'b0;
      frame_ff <= 1'b0;
      irdy_ff <= 1'b0;
      oe_ff <= 1'b0;
      wr_ff <= 1'b0;
      ad_ff <= 32'h0000_0000;
      cbe_ff <= 4'hf;
      idsel_ff <= 1'b0;
      hst_done_ff <= 1'b0;
      hst_rdata_ff <= 32'h0000_0000;
    end else begin
      hst_done_ff <= 1'b0;
      if (hst_start) pend_ff <= 1'b1;
      unique case (st_ff)
        HS_IDLE: if (go) begin
          st_ff <= HS_ADDR;
          frame_ff <= 1'b1;
          oe_ff <= 1'b1;
          ad_ff <= hst_addr;
          cbe_ff <= hst_cmd;
          wr_ff <= hst_cmd[0];
          idsel_ff <= cfg_sel_in;
        end
        HS_ADDR: begin
          st_ff <= HS_DATA;
          frame_ff <= 1'b0; // single data phase
          irdy_ff <= 1'b1;
          ad_ff <= hst_wdata;
          cbe_ff <= hst_be;
          oe_ff <= 1'b1;
        end
        HS_DATA: if (xfer || !bus.stop_n || hto_ff == 3'(ABORT_CYCLES)) begin
          st_ff <= HS_TURN;
          irdy_ff <= 1'b0;
          hst_done_ff <= 1'b1;
          if (!wr_ff) hst_rdata_ff <= bus.ad;
          pend_ff <= 1'b0;
        end
        HS_TURN: begin
          st_ff <= HS_IDLE;
          oe_ff <= 1'b0;
          idsel_ff <= 1'b0;
        end
        default: st_ff <= HS_IDLE;
      endcase
    end
  end
  // ==========================================================
  // parity follows initiator-driven address/data by one clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      par_ff <= 1'b0;
      par_oe_ff <= 1'b0;
      serr_seen_ff <= 1'b0;
      devsel_ff <= 1'b0;
      trdy_ff <= 1'b0;
      twr_ff <= 1'b0;
      mem_ff <= 32'h0000_0000;
      hto_ff <= 3'h0;
    end else begin
      par_ff <= ^{ad_ff, cbe_ff};
      par_oe_ff <= oe_ff && (wr_ff || st_ff != HS_DATA);
      serr_seen_ff <= !bus.serr_n_dev_o;
      devsel_ff <= mem_claim || (devsel_ff && !xfer);
      trdy_ff <= mem_claim || (trdy_ff && !xfer);
      // unclaimed cycles give up, else the host would hang in its data phase
      hto_ff <= (st_ff == HS_DATA && bus.devsel_n) ? hto_ff + 3'h1 : 3'h0;
      if (mem_claim) twr_ff <= bus.cbe[0];
      for (int i = 0; i < 4; i++) begin
        if (devsel_ff && twr_ff && xfer && !bus.cbe[i]) mem_ff[8*i +: 8] <= bus.ad[8*i +: 8];
      end
    end
  end
  // ==========================================================
  // pin drive; read data phase leaves lines to the target
  assign bus.ad_host_o = devsel_ff ? mem_ff : ad_ff;
  assign bus.ad_host_oe = (oe_ff && (st_ff == HS_ADDR || wr_ff)) || (devsel_ff && !twr_ff);
  assign bus.cbe_host_o = cbe_ff;
  assign bus.cbe_host_oe = oe_ff;
  assign bus.par_host_o = par_ff;
  assign bus.par_host_oe = par_oe_ff;
  assign bus.frame_n_host_o = !frame_ff;
  assign bus.frame_n_host_oe = oe_ff;
  assign bus.irdy_n_host_o = !irdy_ff;
  assign bus.irdy_n_host_oe = oe_ff;
  assign bus.trdy_n_host_o = !trdy_ff;
  assign bus.trdy_n_host_oe = devsel_ff;
  assign bus.devsel_n_host_o = !devsel_ff;
  assign bus.devsel_n_host_oe = devsel_ff;
  assign bus.stop_n_host_o = 1'b1;
  assign bus.stop_n_host_oe = devsel_ff;
  assign bus.gnt_n = !gnt_ff;
  assign bus.idsel = idsel_ff;
endmodule // ppb_host
`default_nettype wire

// [ppb_pkg.sv]
// package of bus commands, register offsets and timing counts for the primary bus interface
`default_nettype none
package ppb_pkg;
  // ==========================================================
  // bus commands carried on the command/byte-enable lines
  localparam logic [3:0] CMD_IO_READ = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE = 4'h3;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_CFG_READ = 4'ha;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
  // ==========================================================
  // configuration register offsets (byte addresses) and fields
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_BRIDGE_CTRL = 8'h3c; // word holding the 3eh half
  localparam logic [7:0] OFS_MF_ROUTING = 8'h8c;
  localparam int CMD_PERR_EN_BIT = 6;
  localparam int CMD_SERR_EN_BIT = 8;
  localparam int BRC_CB_SERR_BIT = 17; // bit 1 of the 3eh half-word
  localparam int MF7_LSB = 28; // terminal 7 routing field
  localparam logic [3:0] MF7_SEL_LOCK = 4'h1;
  localparam logic [31:0] RST_COMMAND = 32'h0000_0000;
  localparam logic [31:0] RST_BRIDGE_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_MF_ROUTING = 32'h0000_0000;
  // ==========================================================
  // timing: master abort after this many clocks without a claim
  localparam int ABORT_CYCLES = 5;
  localparam int ADDR_IDSEL_ALT = 23;
endpackage : ppb_pkg
`default_nettype wire

// [ppb_tb.sv]
// self-checking bench joining the device and host ends of the primary bus
`default_nettype none
module ppb_tb
  import ppb_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ABORT_TB = 3; // short abort so the run stays brief
  logic ref_clk = 1'b0, rst_n = 1'b0, latch_strap = 1'b1, sys_err = 1'b0;
  logic card_addr_perr = 1'b0, mst_start = 1'b0, mst_write = 1'b0, park = 1'b0;
  logic cfg_sel_in = 1'b0, hst_start = 1'b0, req_seen = 1'b0, ab_seen = 1'b0;
  logic [3:0] mst_cmd = 4'h0, mst_be = 4'h0, hst_cmd = 4'h0, hst_be = 4'h0;
  logic [31:0] mst_addr = 32'h0, mst_wdata = 32'h0, hst_addr = 32'h0, hst_wdata = 32'h0;
  logic mst_done_ff, mst_abort_ff, lock_sel_ff, hst_done_ff, serr_seen_ff;
  logic [31:0] mst_rdata_ff, cmd_reg_ff, hst_rdata_ff;
  int err_total = 0, checks_done = 0, serr_cnt = 0, hserr_cnt = 0, perr_cnt = 0;
  // ==========================================================
  // clock, ends and checker
  always #50 ref_clk = ~ref_clk;
  ppb_bus_if bus_if();
  ppb_device #(.ABORT_LIMIT(ABORT_TB)) u_ppb_device (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus(bus_if), .latch_strap(latch_strap), .sys_err(sys_err),
    .card_addr_perr(card_addr_perr), .mst_start(mst_start), .mst_write(mst_write),
    .mst_cmd(mst_cmd), .mst_addr(mst_addr), .mst_wdata(mst_wdata), .mst_be(mst_be),
    .mst_done_ff(mst_done_ff), .mst_abort_ff(mst_abort_ff), .mst_rdata_ff(mst_rdata_ff),
    .lock_sel_ff(lock_sel_ff), .cmd_reg_ff(cmd_reg_ff));
  ppb_host u_ppb_host (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus_if), .park(park),
    .cfg_sel_in(cfg_sel_in), .hst_start(hst_start), .hst_cmd(hst_cmd), .hst_addr(hst_addr),
    .hst_wdata(hst_wdata), .hst_be(hst_be), .hst_done_ff(hst_done_ff),
    .hst_rdata_ff(hst_rdata_ff), .serr_seen_ff(serr_seen_ff));
  ppb_chk #(.ABORT_LIMIT(ABORT_TB)) u_ppb_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .cbe(bus_if.cbe), .frame_n(bus_if.frame_n), .irdy_n(bus_if.irdy_n),
    .trdy_n(bus_if.trdy_n), .devsel_n(bus_if.devsel_n), .idsel(bus_if.idsel),
    .gnt_n(bus_if.gnt_n), .serr_n_dev_o(bus_if.serr_n_dev_o), .ad_dev_o(bus_if.ad_dev_o),
    .ad_dev_oe(bus_if.ad_dev_oe), .cbe_dev_o(bus_if.cbe_dev_o),
    .cbe_dev_oe(bus_if.cbe_dev_oe), .par_dev_o(bus_if.par_dev_o),
    .par_dev_oe(bus_if.par_dev_oe), .frame_n_dev_o(bus_if.frame_n_dev_o),
    .frame_n_dev_oe(bus_if.frame_n_dev_oe), .irdy_n_dev_o(bus_if.irdy_n_dev_o),
    .irdy_n_dev_oe(bus_if.irdy_n_dev_oe), .trdy_n_dev_o(bus_if.trdy_n_dev_o),
    .trdy_n_dev_oe(bus_if.trdy_n_dev_oe), .devsel_n_dev_o(bus_if.devsel_n_dev_o),
    .devsel_n_dev_oe(bus_if.devsel_n_dev_oe));
  // serr and request seen on the wire, sampled mid-cycle where settled
  always @(negedge ref_clk) begin
    if (bus_if.serr_n_dev_o === 1'b0) serr_cnt++;
    if (bus_if.req_n === 1'b0) req_seen = 1'b1;
    if (serr_seen_ff === 1'b1) hserr_cnt++;
    if (bus_if.perr_n === 1'b0) perr_cnt++;
  end
  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic strap);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    latch_strap <= strap;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  // host initiator: request fields held until done
  task automatic host_xfer(input logic [3:0] cmd, input logic [31:0] addr,
                           input logic [31:0] wd, input logic [3:0] be, input logic sel);
    @(posedge ref_clk);
    hst_cmd <= cmd;
    hst_addr <= addr;
    hst_wdata <= wd;
    hst_be <= be;
    cfg_sel_in <= sel;
    hst_start <= 1'b1;
    @(posedge ref_clk);
    hst_start <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      if (hst_done_ff === 1'b1) break;
    end
    chk("host done", 32'h1, {31'h0, hst_done_ff});
    @(posedge ref_clk);
    cfg_sel_in <= 1'b0;
  endtask
  task automatic cfg_wr(input logic [7:0] ofs, input logic [31:0] wd, input logic [3:0] be);
    host_xfer(CMD_CFG_WRITE, {24'h0, ofs}, wd, be, 1'b1);
  endtask
  // device initiator: abort and request flags gathered while waiting
  task automatic dev_xfer(input logic [3:0] cmd, input logic wr, input logic [31:0] wd,
                          input logic [3:0] be);
    @(posedge ref_clk);
    mst_cmd <= cmd;
    mst_write <= wr;
    mst_addr <= 32'h0000_0100;
    mst_wdata <= wd;
    mst_be <= be;
    mst_start <= 1'b1;
    req_seen = 1'b0;
    ab_seen = 1'b0;
    @(posedge ref_clk);
    mst_start <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      if (mst_abort_ff === 1'b1) ab_seen = 1'b1;
      if (mst_done_ff === 1'b1) break;
    end
    chk("device done", 32'h1, {31'h0, mst_done_ff});
    @(posedge ref_clk);
  endtask
  task automatic pulse_err(input logic card);
    @(posedge ref_clk);
    sys_err <= !card;
    card_addr_perr <= card;
    @(posedge ref_clk);
    sys_err <= 1'b0;
    card_addr_perr <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    do_reset(1'b1);
    pulse_err(1'b0);
    pulse_err(1'b1);
    chk("serr while disabled", 32'h0, serr_cnt);
    $display("test serr gating done");
    cfg_wr(OFS_COMMAND, 32'h0000_0040, 4'hd);
    chk("masked lane 0", 32'h0, cmd_reg_ff);
    cfg_wr(OFS_COMMAND, 32'h0000_0140, 4'hc);
    chk("lanes 0 and 1", 32'h0000_0140, cmd_reg_ff);
    host_xfer(CMD_CFG_READ, 32'h0000_0004, 32'h0, 4'h0, 1'b1);
    chk("command readback", 32'h0000_0140, hst_rdata_ff);
    $display("test config access done");
    pulse_err(1'b1);
    chk("card error, bridge off", 32'h0, serr_cnt);
    pulse_err(1'b0);
    chk("system error pulse", 32'h1, serr_cnt);
    cfg_wr(OFS_BRIDGE_CTRL, 32'h0002_0000, 4'h0);
    pulse_err(1'b1);
    chk("card error, bridge on", 32'h2, serr_cnt);
    chk("host saw serr", 32'h2, hserr_cnt);
    $display("test system error done");
    host_xfer(CMD_IO_WRITE, 32'h0000_0004, 32'h0, 4'h0, 1'b1);
    chk("io write ignored", 32'h0000_0140, cmd_reg_ff);
    $display("test non-config ignored done");
    dev_xfer(CMD_MEM_WRITE, 1'b1, 32'hc3a5_5a3c, 4'h0);
    chk("request raised", 32'h1, {31'h0, req_seen});
    chk("write claimed", 32'h0, {31'h0, ab_seen});
    dev_xfer(CMD_MEM_WRITE, 1'b1, 32'hffff_ffff, 4'hc);
    dev_xfer(CMD_MEM_READ, 1'b0, 32'h0, 4'h0);
    chk("merged readback", 32'hc3a5_ffff, mst_rdata_ff);
    park <= 1'b1;
    dev_xfer(CMD_MEM_READ, 1'b0, 32'h0, 4'h0);
    chk("parked read", 32'hc3a5_ffff, mst_rdata_ff);
    park <= 1'b0;
    dev_xfer(CMD_IO_READ, 1'b0, 32'h0, 4'h0);
    chk("master abort", 32'h1, {31'h0, ab_seen});
    $display("test device initiator done");
    cfg_wr(OFS_MF_ROUTING, {MF7_SEL_LOCK, 28'h0}, 4'h0);
    @(negedge ref_clk);
    chk("no lock, strap high", 32'h0, {31'h0, lock_sel_ff});
    do_reset(1'b0);
    chk("command after reset", RST_COMMAND, cmd_reg_ff);
    host_xfer(CMD_CFG_WRITE, 32'h0080_0004, 32'h0000_0040, 4'h0, 1'b0);
    chk("select from ad23", 32'h0000_0040, cmd_reg_ff);
    host_xfer(CMD_CFG_WRITE, 32'h0080_008c, {MF7_SEL_LOCK, 28'h0}, 4'h0, 1'b0);
    @(negedge ref_clk);
    chk("terminal 7 lock", 32'h1, {31'h0, lock_sel_ff});
    chk("no parity error", 32'h0, perr_cnt);
    $display("test strap select done");
    wrap_up();
  end
  // hang guard, far beyond the few hundred clocks the tests need
  initial begin
    #(20000 * 100);
    err_total++;
    wrap_up();
  end
endmodule // ppb_tb
`default_nettype wire
